// ==== msbr_bridge.v ====
// Multidrop scan bridge with selection control and local port routing
//
// Summary of operation
// - Unselected bridge watches the backplane, ignores level two, still obeys return-to-wait.
// - Unselected bridge hides its data registers and local ports from the master.
// - Selected with all ports parked, only the current bridge register is in path.
// - Unparked path: serial in, bridge register, local ring, pad bit, serial out.
// - A one-bit pad register follows every local port chain.
// - The pad bit samples the local return on the test clock falling edge.
// - Addressing only selects a bridge; later operations form a second level.
// - A singly selected bridge behaves as a standard test access port.
// - A sixteen-state controller drives standard instruction and data registers.
// - Received address is compared with slot inputs; a match selects the bridge.
// - Port controllers follow the instruction, mode register and controller state.
// - Each local port gives clock, mode select, data out, data in and reset.
// - Backplane mode select steers the bridge and the unparked local controllers.
// - All backplane scan data enters through the single backplane serial input.
// - Bit 0 is the rightmost, least significant bit of every register.
// - The master selects a bridge by shifting its slot value into the instruction.
// - A parked port holds its mode select output constant.
// - The backplane test clock paces all bridge and local port scanning.
// - Active-low backplane test reset initialises all bridge logic except the input synchroniser and test clock edge detector.
`timescale 1ns/1ns
`include "msbr_regs.vh"
module msbr_bridge (
   // Clock and reset
   input  wire                     clk_i,
   input  wire                     sys_rst_i,
   // Backplane scan pins
   input  wire                     backplane_test_clock_i,
   input  wire                     backplane_test_reset_n_i,
   input  wire                     backplane_mode_select_i,
   input  wire                     backplane_serial_in_i,
   output reg                      backplane_serial_out_o,
   output reg                      backplane_serial_out_oe_o,
   output reg                      backplane_tristate_o,
   // Slot identification and local output enable
   input  wire [`MSBR_SLOT_W-1:0]  slot_id_i,
   input  wire                     local_output_enable_n_i,
   // Local scan ports
   output reg  [`MSBR_PORTS-1:0]   local_test_clock_o,
   output reg  [`MSBR_PORTS-1:0]   local_mode_select_out_o,
   output reg  [`MSBR_PORTS-1:0]   local_serial_out_o,
   output reg  [`MSBR_PORTS-1:0]   local_serial_out_oe_o,
   output reg  [`MSBR_PORTS-1:0]   local_tristate_o,
   output reg  [`MSBR_PORTS-1:0]   local_test_reset_n_o,
   input  wire [`MSBR_PORTS-1:0]   local_serial_return_i,
   // Status
   output reg                      bridge_selected_o,
   output reg  [`MSBR_STATE_W-1:0] tap_state_o
);

   // Synchronised inputs
   wire [`MSBR_SYNC_W-1:0]  sync_q;
   wire                     tck_s;
   wire                     trst_n_s;
   wire                     tms_s;
   wire                     tdi_s;
   wire                     oe_n_s;
   wire [`MSBR_PORTS-1:0]   ret_s;
   wire [`MSBR_SLOT_W-1:0]  slot_s;

   msbr_sync #(
      .W (`MSBR_SYNC_W)
   ) u_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       ({backplane_test_clock_i, backplane_test_reset_n_i,
                   backplane_mode_select_i, backplane_serial_in_i,
                   local_output_enable_n_i, local_serial_return_i, slot_id_i}),
      .q_o       (sync_q)
   );

   assign {tck_s, trst_n_s, tms_s, tdi_s, oe_n_s, ret_s, slot_s} = sync_q;

   // Test clock edge detection
   reg  tck_prev_reg;
   wire tck_rise;
   wire tck_fall;
   wire init;

   assign tck_rise = tck_s & ~tck_prev_reg;
   assign tck_fall = ~tck_s & tck_prev_reg;
   assign init     = sys_rst_i | ~trst_n_s;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         tck_prev_reg <= 1'b0;
      end else begin
         tck_prev_reg <= tck_s;
      end
   end

   // Central controller
   wire [`MSBR_STATE_W-1:0] state;

   msbr_tap_fsm u_tap (
      .clk_i         (clk_i),
      .init_i        (init),
      .step_i        (tck_rise),
      .mode_select_i (tms_s),
      .state_o       (state)
   );

   // Data register selected by the instruction
   function dr_is_mode;
      input [`MSBR_IR_W-1:0] ir;
      begin
         dr_is_mode = (ir == `MSBR_IR_MODE);
      end
   endfunction

   // Address match against the slot identification
   function addr_match;
      input [`MSBR_IR_W-1:0]   ir;
      input [`MSBR_SLOT_W-1:0] slot;
      begin
         addr_match = (ir[`MSBR_IR_W-1] == `MSBR_ADDR_TOP) &&
                      (ir[`MSBR_SLOT_W-1:0] == slot);
      end
   endfunction

   // Instruction, data and selection state
   reg [`MSBR_IR_W-1:0]   ir_reg;
   reg [`MSBR_IR_W-1:0]   ir_sr_reg;
   reg                    bypass_reg;
   reg [`MSBR_MODE_W-1:0] mode_sr_reg;
   reg [`MSBR_MODE_W-1:0] mode_reg;
   reg                    selected_reg;
   reg [`MSBR_PORTS-1:0]  unparked_reg;

   wire sel_dr_mode;
   wire dr_access;

   assign sel_dr_mode = dr_is_mode(ir_reg);
   assign dr_access   = selected_reg;

   always @(posedge clk_i) begin
      if (init) begin
         ir_reg       <= `MSBR_IR_BYPASS;
         ir_sr_reg    <= `MSBR_IR_CAPTURE;
         bypass_reg   <= 1'b0;
         mode_sr_reg  <= `MSBR_MODE_RST;
         mode_reg     <= `MSBR_MODE_RST;
         selected_reg <= 1'b0;
         unparked_reg <= `MSBR_PARK_ALL;
      end else if (tck_rise) begin
         case (state)
            `MSBR_TLR: begin
               ir_reg <= `MSBR_IR_BYPASS;
            end
            `MSBR_CAP_IR: begin
               ir_sr_reg <= `MSBR_IR_CAPTURE;
            end
            `MSBR_SHIFT_IR: begin
               // Instruction shift runs in both levels for addressing
               ir_sr_reg <= {tdi_s, ir_sr_reg[`MSBR_IR_W-1:1]};
            end
            `MSBR_UPD_IR: begin
               if (ir_sr_reg == `MSBR_IR_WAIT) begin
                  selected_reg <= 1'b0;
                  unparked_reg <= `MSBR_PARK_ALL;
                  ir_reg       <= `MSBR_IR_BYPASS;
               end else if (!selected_reg) begin
                  if (addr_match(ir_sr_reg, slot_s)) begin
                     selected_reg <= 1'b1;
                     ir_reg       <= `MSBR_IR_BYPASS;
                  end
               end else begin
                  ir_reg <= ir_sr_reg;
                  if (ir_sr_reg == `MSBR_IR_UNPARK) begin
                     unparked_reg <= mode_reg;
                  end else if (ir_sr_reg == `MSBR_IR_PARK) begin
                     unparked_reg <= `MSBR_PARK_ALL;
                  end
               end
            end
            `MSBR_CAP_DR: begin
               if (dr_access) begin
                  bypass_reg  <= 1'b0;
                  mode_sr_reg <= mode_reg;
               end
            end
            `MSBR_SHIFT_DR: begin
               if (dr_access) begin
                  if (sel_dr_mode) begin
                     mode_sr_reg <= {tdi_s, mode_sr_reg[`MSBR_MODE_W-1:1]};
                  end else begin
                     bypass_reg <= tdi_s;
                  end
               end
            end
            `MSBR_UPD_DR: begin
               if (dr_access && sel_dr_mode) begin
                  mode_reg <= mode_sr_reg;
               end
            end
            default: begin
               ir_reg <= ir_reg;
            end
         endcase
      end
   end

   // Serial routing through the local port network
   wire                  shift_ir;
   wire                  shift_dr;
   wire                  drive_out;
   wire                  bridge_bit;
   wire [`MSBR_PORTS:0]  chain;
   wire [`MSBR_PORTS-1:0] port_live;

   assign shift_ir   = (state == `MSBR_SHIFT_IR);
   assign shift_dr   = (state == `MSBR_SHIFT_DR);
   assign drive_out  = selected_reg & (shift_ir | shift_dr);
   assign bridge_bit = shift_ir ? ir_sr_reg[0] :
                       (sel_dr_mode ? mode_sr_reg[0] : bypass_reg);
   assign chain[0]   = bridge_bit;

   genvar k;
   generate
      for (k = 0; k < `MSBR_PORTS; k = k + 1) begin : g_port
         assign port_live[k] = selected_reg & unparked_reg[k];
         // Unparked ring returns through its pad, parked ring is skipped
         assign chain[k+1] = port_live[k] ? ret_s[k] : chain[k];

         always @(posedge clk_i) begin
            if (init) begin
               local_serial_out_o[k]      <= 1'b0;
               local_mode_select_out_o[k] <= 1'b1;
               local_test_clock_o[k]      <= 1'b0;
               local_serial_out_oe_o[k]   <= 1'b0;
               local_tristate_o[k]        <= 1'b1;
               local_test_reset_n_o[k]    <= 1'b0;
            end else begin
               if (tck_fall) begin
                  // Data to this ring; for k above zero this flop is the pad
                  local_serial_out_o[k] <= chain[k];
               end
               if (port_live[k]) begin
                  local_mode_select_out_o[k] <= tms_s;
               end else begin
                  local_mode_select_out_o[k] <= local_mode_select_out_o[k];
               end
               local_test_clock_o[k]    <= tck_s;
               local_serial_out_oe_o[k] <= port_live[k] & ~oe_n_s;
               local_tristate_o[k]      <= ~(port_live[k] & ~oe_n_s);
               local_test_reset_n_o[k]  <= trst_n_s;
            end
         end
      end
   endgenerate

   // Backplane output stage, last pad bit on the return path
   always @(posedge clk_i) begin
      if (init) begin
         backplane_serial_out_o    <= 1'b0;
         backplane_serial_out_oe_o <= 1'b0;
         backplane_tristate_o      <= 1'b1;
         bridge_selected_o         <= 1'b0;
         tap_state_o               <= `MSBR_TLR;
      end else begin
         if (tck_fall) begin
            backplane_serial_out_o    <= chain[`MSBR_PORTS];
            backplane_serial_out_oe_o <= drive_out;
            backplane_tristate_o      <= ~drive_out;
         end
         bridge_selected_o <= selected_reg;
         tap_state_o       <= state;
      end
   end

endmodule

// ==== msbr_chk.sv ====
// Port assertions for the scan bridge
`timescale 1ns/1ns
`include "msbr_regs.vh"
module msbr_chk (
   // Clock, reset and controls
   input wire                     clk_i,
   input wire                     sys_rst_i,
   input wire                     backplane_test_reset_n_i,
   input wire                     local_output_enable_n_i,
   // Observed outputs
   input wire                     backplane_serial_out_oe_o,
   input wire                     backplane_tristate_o,
   input wire [`MSBR_PORTS-1:0]   local_mode_select_out_o,
   input wire [`MSBR_PORTS-1:0]   local_serial_out_oe_o,
   input wire [`MSBR_PORTS-1:0]   local_tristate_o,
   input wire                     bridge_selected_o,
   input wire [`MSBR_STATE_W-1:0] tap_state_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   tri_flag_a: assert property (
      backplane_tristate_o == !backplane_serial_out_oe_o) else $error("flag disagrees");
   unsel_quiet_a: assert property (
      !bridge_selected_o && !$past(bridge_selected_o) |-> !backplane_serial_out_oe_o)
      else $error("unselected bridge drives out");
   unsel_ports_a: assert property (
      !bridge_selected_o && !$past(bridge_selected_o) |-> local_serial_out_oe_o == 3'h0)
      else $error("unselected bridge opens ports");
   port_flag_a: assert property (
      local_tristate_o == ~local_serial_out_oe_o) else $error("port flag wrong");
   oe_off_a: assert property (
      local_output_enable_n_i [*4] |-> local_serial_out_oe_o == 3'h0)
      else $error("ports driven while disabled");
   park_hold_a: assert property (
      (backplane_test_reset_n_i && !local_output_enable_n_i
       && local_serial_out_oe_o == 3'h0) [*6] |-> $stable(local_mode_select_out_o))
      else $error("parked mode select moved");
   oe_shift_a: assert property (
      $rose(backplane_serial_out_oe_o) |-> tap_state_o == `MSBR_SHIFT_DR
      || tap_state_o == `MSBR_SHIFT_IR) else $error("out enabled outside shift");
   shift_exit_a: assert property (
      $past(tap_state_o) == `MSBR_SHIFT_DR && tap_state_o != `MSBR_SHIFT_DR
      |-> tap_state_o == `MSBR_EXIT1_DR || tap_state_o == `MSBR_TLR)
      else $error("bad exit from shift");
   sel_on_upd_a: assert property (
      $rose(bridge_selected_o) |-> $past(tap_state_o) == `MSBR_UPD_IR)
      else $error("selected outside update");
endmodule

bind msbr_bridge msbr_chk msbr_chk_inst (.clk_i, .sys_rst_i, .backplane_test_reset_n_i,
   .local_output_enable_n_i, .backplane_serial_out_oe_o, .backplane_tristate_o,
   .local_mode_select_out_o, .local_serial_out_oe_o, .local_tristate_o,
   .bridge_selected_o, .tap_state_o);

// ==== msbr_master.sv ====
// Backplane test master model
`timescale 1ns/1ns
module msbr_master (
   // Backplane pins
   output reg  tck_o,
   output reg  tms_o,
   output reg  tdi_o,
   input  wire tdo_i,
   input  wire tdo_oe_i
);
   reg saw_oe;
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
      saw_oe = 1'b0;
   end
   // One test clock period; clock stands low between calls
   task tick(input m, input d, output q);
      begin
         tms_o = m;
         tdi_o = d;
         #80 tck_o = 1'b1;
         #79 q = tdo_i;
         saw_oe = saw_oe | tdo_oe_i;
         #1 tck_o = 1'b0;
      end
   endtask
   task go_idle;
      reg q;
      begin
         repeat (5) tick(1'b1, 1'b1, q);
         tick(1'b0, 1'b1, q);
      end
   endtask
   // Scan from idle back to idle, LSB first
   task shift(input ir, input [5:0] n, input [31:0] d, output [31:0] cap);
      integer i;
      reg     q;
      begin
         cap = 32'h0;
         tick(1'b1, 1'b1, q);
         if (ir) tick(1'b1, 1'b1, q);
         tick(1'b0, 1'b1, q);
         tick(1'b0, 1'b1, q);
         for (i = 0; i < n; i = i + 1) begin
            tick(i == n - 1, d[i], q);
            cap[i] = q;
         end
         tick(1'b1, 1'b1, q);
         tick(1'b0, 1'b1, q);
      end
   endtask
endmodule

// ==== msbr_regs.vh ====
// Constants for the multidrop scan bridge routing core
`ifndef MSBR_REGS_VH
`define MSBR_REGS_VH

// Widths and counts
`define MSBR_IR_W        8
`define MSBR_SLOT_W      7
`define MSBR_PORTS       3
`define MSBR_MODE_W      3
`define MSBR_STATE_W     4
`define MSBR_SYNC_W      15

// Instruction codes
`define MSBR_IR_BYPASS   8'hff
`define MSBR_IR_WAIT     8'h03
`define MSBR_IR_MODE     8'h81
`define MSBR_IR_PARK     8'he2
`define MSBR_IR_UNPARK   8'he1
`define MSBR_IR_CAPTURE  8'h01
`define MSBR_ADDR_TOP    1'b0

// Reset values
`define MSBR_MODE_RST    3'h0
`define MSBR_PARK_ALL    3'h0

// TAP controller states
`define MSBR_TLR         4'hf
`define MSBR_RTI         4'hc
`define MSBR_SEL_DR      4'h7
`define MSBR_CAP_DR      4'h6
`define MSBR_SHIFT_DR    4'h2
`define MSBR_EXIT1_DR    4'h1
`define MSBR_PAUSE_DR    4'h3
`define MSBR_EXIT2_DR    4'h0
`define MSBR_UPD_DR      4'h5
`define MSBR_SEL_IR      4'h4
`define MSBR_CAP_IR      4'he
`define MSBR_SHIFT_IR    4'ha
`define MSBR_EXIT1_IR    4'h9
`define MSBR_PAUSE_IR    4'hb
`define MSBR_EXIT2_IR    4'h8
`define MSBR_UPD_IR      4'hd

`endif

// ==== msbr_sync.v ====
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module msbr_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clk_i,
   input  wire         sys_rst_i,
   // Data
   input  wire [W-1:0] d_i,
   output reg  [W-1:0] q_o
);

   reg [W-1:0] meta_reg;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_reg <= {W{1'b0}};
         q_o      <= {W{1'b0}};
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end

endmodule

// ==== msbr_tap_fsm.v ====
// Sixteen-state test access port controller
`timescale 1ns/1ns
`include "msbr_regs.vh"
module msbr_tap_fsm (
   // Clock and reset
   input  wire                     clk_i,
   input  wire                     init_i,
   // Backplane sampling
   input  wire                     step_i,
   input  wire                     mode_select_i,
   // State
   output reg  [`MSBR_STATE_W-1:0] state_o
);

   reg [`MSBR_STATE_W-1:0] state_next;

   always @* begin
      case (state_o)
         `MSBR_TLR:      state_next = mode_select_i ? `MSBR_TLR     : `MSBR_RTI;
         `MSBR_RTI:      state_next = mode_select_i ? `MSBR_SEL_DR  : `MSBR_RTI;
         `MSBR_SEL_DR:   state_next = mode_select_i ? `MSBR_SEL_IR  : `MSBR_CAP_DR;
         `MSBR_CAP_DR:   state_next = mode_select_i ? `MSBR_EXIT1_DR : `MSBR_SHIFT_DR;
         `MSBR_SHIFT_DR: state_next = mode_select_i ? `MSBR_EXIT1_DR : `MSBR_SHIFT_DR;
         `MSBR_EXIT1_DR: state_next = mode_select_i ? `MSBR_UPD_DR  : `MSBR_PAUSE_DR;
         `MSBR_PAUSE_DR: state_next = mode_select_i ? `MSBR_EXIT2_DR : `MSBR_PAUSE_DR;
         `MSBR_EXIT2_DR: state_next = mode_select_i ? `MSBR_UPD_DR  : `MSBR_SHIFT_DR;
         `MSBR_UPD_DR:   state_next = mode_select_i ? `MSBR_SEL_DR  : `MSBR_RTI;
         `MSBR_SEL_IR:   state_next = mode_select_i ? `MSBR_TLR     : `MSBR_CAP_IR;
         `MSBR_CAP_IR:   state_next = mode_select_i ? `MSBR_EXIT1_IR : `MSBR_SHIFT_IR;
         `MSBR_SHIFT_IR: state_next = mode_select_i ? `MSBR_EXIT1_IR : `MSBR_SHIFT_IR;
         `MSBR_EXIT1_IR: state_next = mode_select_i ? `MSBR_UPD_IR  : `MSBR_PAUSE_IR;
         `MSBR_PAUSE_IR: state_next = mode_select_i ? `MSBR_EXIT2_IR : `MSBR_PAUSE_IR;
         `MSBR_EXIT2_IR: state_next = mode_select_i ? `MSBR_UPD_IR  : `MSBR_SHIFT_IR;
         `MSBR_UPD_IR:   state_next = mode_select_i ? `MSBR_SEL_DR  : `MSBR_RTI;
         default:        state_next = `MSBR_TLR;
      endcase
   end

   always @(posedge clk_i) begin
      if (init_i) begin
         state_o <= `MSBR_TLR;
      end else if (step_i) begin
         state_o <= state_next;
      end
   end

endmodule

// ==== testbench.sv ====
// Self-checking bench for the scan bridge
`timescale 1ns/1ns
`include "msbr_regs.vh"
module testbench;
   reg         clk_i;
   reg         sys_rst_i;
   reg         trst_n;
   reg         oe_n;
   reg  [6:0]  slot;
   wire        tck, tms, tdi, tdo, tdo_oe, tri_b, sel, tdo_bus;
   wire [2:0]  lck, ltms, lout, loe, ltri, lret, lrst;
   wire [3:0]  st;
   integer     n_fail, compares;
   reg  [31:0] cap;

   msbr_bridge msbr_bridge_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .backplane_test_clock_i(tck), .backplane_test_reset_n_i(trst_n),
      .backplane_mode_select_i(tms), .backplane_serial_in_i(tdi),
      .backplane_serial_out_o(tdo), .backplane_serial_out_oe_o(tdo_oe),
      .backplane_tristate_o(tri_b), .slot_id_i(slot), .local_output_enable_n_i(oe_n),
      .local_test_clock_o(lck), .local_mode_select_out_o(ltms),
      .local_serial_out_o(lout), .local_serial_out_oe_o(loe), .local_tristate_o(ltri),
      .local_test_reset_n_o(lrst), .local_serial_return_i(lret),
      .bridge_selected_o(sel), .tap_state_o(st));
   msbr_master msbr_master_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
      .tdo_i(tdo_bus), .tdo_oe_i(tdo_oe));
   // Undriven return line shows the inverse of the last value
   assign tdo_bus = tdo_oe ? tdo : ~tdo;

   // Local rings of 2, 3 and 4 stages
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : ring_g
         reg [3:0] sr = 4'h0;
         reg [3:0] st_q = 4'h0;
         reg       q = 1'b0;
         always @(negedge lck[g]) begin
            st_q <= st;
            q <= sr[2-g];
         end
         always @(posedge lck[g]) begin
            if (st_q == `MSBR_SHIFT_DR || st_q == `MSBR_SHIFT_IR) sr <= {lout[g], sr[3:1]};
         end
         assign lret[g] = q;
      end
   endgenerate

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task check(input string what, input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("compares %0d n_fail %0d", compares, n_fail);
         if (n_fail == 0 && compares > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   task ir(input [31:0] d, input [5:0] n);
      msbr_master_inst.shift(1'b1, n, d, cap);
   endtask
   // Walk a pattern through the data chain of the given length
   task chain(input [5:0] len);
      reg [31:0] d, m;
      begin
         d = 32'h00a5c39b;
         m = 32'h00ffffff >> len;
         msbr_master_inst.shift(1'b0, 6'd24, d, cap);
         check("chain", (cap >> len) & m, d & m);
      end
   endtask

   task t_unsel;
      begin
         ir(32'h2b, 6'd8);
         ir(32'h81, 6'd8);
         msbr_master_inst.shift(1'b0, 6'd3, 32'h7, cap);
         ir(32'he1, 6'd8);
         check("selected", sel, 0);
         check("out driven", msbr_master_inst.saw_oe, 0);
         check("tristate", tri_b, 1);
         check("local mode", ltms, 3'h7);
      end
   endtask
   task t_select;
      begin
         ir({25'h0, slot}, 6'd8);
         check("selected", sel, 1);
         ir(32'hff, 6'd8);
         check("ir capture", cap[7:0], 8'h01);
         check("ports", loe, 3'h0);
         chain(6'd1);
         check("out driven", msbr_master_inst.saw_oe, 1);
         check("port reset", lrst, 3'h7);
      end
   endtask
   task t_unpark;
      begin
         ir(32'h81, 6'd8);
         msbr_master_inst.shift(1'b0, 6'd3, 32'h5, cap);
         ir(32'he1, 6'd8);
         check("port oe", loe, 3'h5);
         check("port flags", ltri, 3'h2);
         ir(32'h00ffffff, 6'd24);
         chain(6'd9);
         @(posedge clk_i);
         #2 oe_n = 1'b1;
         repeat (6) @(posedge clk_i);
         check("port flags off", ltri, 3'h7);
         #2 oe_n = 1'b0;
         ir(32'h00e2ffff, 6'd24);
         check("parked", loe, 3'h0);
         ir(32'hff, 6'd8);
         chain(6'd1);
      end
   endtask
   task t_leave;
      begin
         ir(32'h03, 6'd8);
         check("wait deselects", sel, 0);
         ir({25'h0, slot}, 6'd8);
         check("reselected", sel, 1);
         @(posedge clk_i);
         #2 trst_n = 1'b0;
         repeat (4) @(posedge clk_i);
         #2 check("reset deselects", sel, 0);
         check("reset state", st, `MSBR_TLR);
         check("port reset", lrst, 3'h0);
         trst_n = 1'b1;
         repeat (4) @(posedge clk_i);
         #2 msbr_master_inst.go_idle;
         check("port reset", lrst, 3'h7);
         check("still idle", sel, 0);
         check("idle state", st, `MSBR_RTI);
      end
   endtask

   initial begin
      #400000;
      n_fail = n_fail + 1;
      print_verdict;
   end
   initial begin
      sys_rst_i = 1'b1;
      trst_n = 1'b1;
      oe_n = 1'b0;
      slot = 7'h2a;
      n_fail = 0;
      compares = 0;
      repeat (3) @(posedge clk_i);
      #2 sys_rst_i = 1'b0;
      repeat (6) @(posedge clk_i);
      #2 msbr_master_inst.go_idle;
      t_unsel;
      t_select;
      t_unpark;
      t_leave;
      print_verdict;
   end
endmodule
